// ### inc/flsq_pkg.sv
// Package with command codes, status bit positions, pin timing and host register map.
package flsq_pkg;
   // Device command codes written on the data bus.
   localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
   localparam logic [7:0] CMD_BLOCK_LOCK   = 8'h01;
   localparam logic [7:0] CMD_MASTER_LOCK  = 8'hf1;
   localparam logic [7:0] CMD_CLEAR_LOCKS  = 8'hd0;
   localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
   // Status byte bit positions.
   localparam int SR_READY   = 7;
   localparam int SR_ESUSP   = 6;
   localparam int SR_ERASE   = 5;
   localparam int SR_WRITE   = 4;
   localparam int SR_SUPPLY  = 3;
   localparam int SR_WSUSP   = 2;
   localparam int SR_PROTECT = 1;
   // Mask that drops the reserved bit 0.
   localparam logic [7:0] SR_MASK = 8'hfe;
   // Strobe phase timing.
   localparam int STROBE_NS     = 100;
   localparam int CLK_NS        = 50;
   localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
   // Host register addresses.
   localparam logic [3:0] A_CTRL   = 4'h0;
   localparam logic [3:0] A_ADDR   = 4'h1;
   localparam logic [3:0] A_STATUS = 4'h2;
   localparam logic [3:0] A_RESULT = 4'h3;
   // Operation codes written into the control register.
   localparam logic [2:0] OP_BLOCK_LOCK   = 3'h1;
   localparam logic [2:0] OP_MASTER_LOCK  = 3'h2;
   localparam logic [2:0] OP_CLEAR_LOCKS  = 3'h3;
   localparam logic [2:0] OP_CLEAR_STATUS = 3'h4;
   localparam logic [2:0] OP_READ_ARRAY   = 3'h5;
   // Sequencer states.
   typedef enum logic [3:0] {
      FLSQ_IDLE, FLSQ_WR1, FLSQ_WR2, FLSQ_POLL, FLSQ_RD, FLSQ_GAP
   } flsq_state_t;
endpackage : flsq_pkg

// ### src/flsq_host.sv
// Host controller that sequences lock-bit commands and status polling on a parallel flash.
//
// Contract
// - Host masks reserved bit 0 when polling.
// - Host trusts bits 6..0 only when ready.
// - Lock set is 60H then 01H or F1H.
// - Clear locks is 60H then D0H.
// - Host writes FFH before reading array again.
// - Host clears status before any retry; the code sends 50H only when software starts OP_CLEAR_STATUS.
// - Full check order: supply, protect, both, error.
`timescale 1ns/1ps
module flsq_host
   import flsq_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // Software register port.
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // Flash bus pins.
   output logic      [19:0] flash_addr,
   input  wire logic [7:0]  flash_dq_in,
   output logic      [7:0]  flash_dq_out,
   output logic             flash_dq_oe,
   output logic             flash_ce_n,
   output logic             flash_we_n,
   output logic             flash_oe_n,
   input  wire logic        ready_busy_output
);
   // Sequencer state.
   flsq_state_t state_q;
   // Operation in progress and its second command byte.
   logic [2:0]  op_q;
   logic [7:0]  cmd2_q;
   // Target address written by software.
   logic [19:0] addr_q;
   // Phase counter for strobe width.
   logic [3:0]  cnt_q;
   // Last masked status byte and the sequencer result flags.
   logic [7:0]  status_q;
   logic        busy_q;
   logic        done_q;
   logic        err_q;

   // Second command byte for each operation code.
   function automatic logic [7:0] confirm_code(input logic [2:0] op);
      case (op)
         OP_BLOCK_LOCK:   confirm_code = CMD_BLOCK_LOCK;
         OP_MASTER_LOCK:  confirm_code = CMD_MASTER_LOCK;
         OP_CLEAR_LOCKS:  confirm_code = CMD_CLEAR_LOCKS;
         OP_CLEAR_STATUS: confirm_code = CMD_CLEAR_STATUS;
         default:         confirm_code = CMD_READ_ARRAY;
      endcase
   endfunction : confirm_code

   // True for operations that are a two-write setup/confirm pair.
   function automatic logic two_write(input logic [2:0] op);
      two_write = (op == OP_BLOCK_LOCK) || (op == OP_MASTER_LOCK) || (op == OP_CLEAR_LOCKS);
   endfunction : two_write

   // A start is a control write with a known operation while idle.
   logic start;
   assign start = reg_wr && (reg_addr == A_CTRL) && (state_q == FLSQ_IDLE)
                  && (reg_wdata[2:0] >= OP_BLOCK_LOCK) && (reg_wdata[2:0] <= OP_READ_ARRAY);

   // Completion: the status read ends with bit 7 set and the ready pin high.
   logic poll_done;
   assign poll_done = (state_q == FLSQ_RD) && (cnt_q == 4'h0) && flash_dq_in[SR_READY]
                      && ready_busy_output;

   // Target address register.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         addr_q <= 20'h00000;
      end else if (reg_wr && reg_addr == A_ADDR) begin
         addr_q <= reg_wdata[19:0];
      end
   end

   // Sequencer: each phase holds pins for STROBE_CNT plus one cycles.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q      <= FLSQ_IDLE;
         op_q         <= 3'h0;
         cmd2_q       <= 8'h00;
         cnt_q        <= 4'h0;
         flash_addr   <= 20'h00000;
         flash_dq_out <= 8'h00;
         flash_dq_oe  <= 1'b0;
         flash_ce_n   <= 1'b1;
         flash_we_n   <= 1'b1;
         flash_oe_n   <= 1'b1;
      end else begin
         case (state_q)
            FLSQ_IDLE: begin
               // Launch the first write of the chosen sequence.
               if (start) begin
                  op_q         <= reg_wdata[2:0];
                  cmd2_q       <= confirm_code(reg_wdata[2:0]);
                  flash_addr   <= addr_q;
                  flash_dq_out <= two_write(reg_wdata[2:0]) ? CMD_LOCK_SETUP
                                  : confirm_code(reg_wdata[2:0]);
                  flash_dq_oe  <= 1'b1;
                  flash_ce_n   <= 1'b0;
                  flash_we_n   <= 1'b0;
                  cnt_q        <= STROBE_CNT;
                  state_q      <= FLSQ_WR1;
               end
            end
            FLSQ_WR1, FLSQ_WR2: begin
               // Hold the write strobe, then release and decide the next phase.
               if (cnt_q != 4'h0) begin
                  cnt_q <= cnt_q - 4'h1;
               end else begin
                  flash_we_n  <= 1'b1;
                  flash_ce_n  <= 1'b1;
                  flash_dq_oe <= 1'b0;
                  cnt_q       <= STROBE_CNT;
                  if (state_q == FLSQ_WR1 && two_write(op_q)) begin
                     state_q <= FLSQ_GAP;
                  end else if (two_write(op_q)) begin
                     state_q <= FLSQ_POLL;
                  end else begin
                     state_q <= FLSQ_IDLE;
                  end
               end
            end
            FLSQ_GAP: begin
               // Recovery time, then the confirm write.
               if (cnt_q != 4'h0) begin
                  cnt_q <= cnt_q - 4'h1;
               end else begin
                  flash_dq_out <= cmd2_q;
                  flash_dq_oe  <= 1'b1;
                  flash_ce_n   <= 1'b0;
                  flash_we_n   <= 1'b0;
                  cnt_q        <= STROBE_CNT;
                  state_q      <= FLSQ_WR2;
               end
            end
            FLSQ_POLL: begin
               // After the confirm the device outputs status on every read.
               if (cnt_q != 4'h0) begin
                  cnt_q <= cnt_q - 4'h1;
               end else begin
                  flash_ce_n <= 1'b0;
                  flash_oe_n <= 1'b0;
                  cnt_q      <= STROBE_CNT;
                  state_q    <= FLSQ_RD;
               end
            end
            FLSQ_RD: begin
               // Sample the status byte at the end of the read strobe.
               if (cnt_q != 4'h0) begin
                  cnt_q <= cnt_q - 4'h1;
               end else begin
                  flash_ce_n <= 1'b1;
                  flash_oe_n <= 1'b1;
                  cnt_q      <= STROBE_CNT;
                  // Completion is judged on bit 7 together with the ready pin.
                  if (flash_dq_in[SR_READY] && ready_busy_output) begin
                     state_q <= FLSQ_IDLE;
                  end else begin
                     state_q <= FLSQ_POLL;
                  end
               end
            end
            default: begin
               state_q <= FLSQ_IDLE;
            end
         endcase
      end
   end

   // Busy flag and completion flag; done is sticky until software reads result.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         // Busy drops on the completing edge; a new start leaves an unread done from an earlier job set.
         if (start) begin
            busy_q <= 1'b1;
         end else if (state_q == FLSQ_IDLE || poll_done) begin
            busy_q <= 1'b0;
         end
         // A completion in the cycle of a clear read wins over the clear.
         if (state_q == FLSQ_RD && cnt_q == 4'h0 && flash_dq_in[SR_READY] && ready_busy_output) begin
            done_q <= 1'b1;
         end else if (reg_rd && reg_addr == A_RESULT) begin
            done_q <= 1'b0;
         end
      end
   end

   // Captured status, masked and interpreted in full-check order.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         status_q <= 8'h00;
         err_q    <= 1'b0;
      end else if (state_q == FLSQ_RD && cnt_q == 4'h0 && flash_dq_in[SR_READY]
                   && ready_busy_output) begin
         status_q <= flash_dq_in & SR_MASK;
         // Supply, protect, sequence and operation errors all fail the job.
         err_q    <= flash_dq_in[SR_SUPPLY] | flash_dq_in[SR_PROTECT]
                     | flash_dq_in[SR_ERASE] | flash_dq_in[SR_WRITE];
      end else if (start && reg_wdata[2:0] == OP_CLEAR_STATUS) begin
         status_q <= 8'h00;
         err_q    <= 1'b0;
      end
   end

   // Register read port with data valid one cycle after the strobe.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         if (reg_addr == A_CTRL) begin
            reg_rdata <= {29'h0, op_q};
         end else if (reg_addr == A_ADDR) begin
            reg_rdata <= {12'h000, addr_q};
         end else if (reg_addr == A_STATUS) begin
            reg_rdata <= {24'h000000, status_q};
         end else if (reg_addr == A_RESULT) begin
            reg_rdata <= {29'h0, err_q, done_q, busy_q};
         end else begin
            reg_rdata <= 32'h00000000;
         end
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // Setup byte always precedes the confirm byte of a lock sequence.
   setup_first_a : assert property (
      @(posedge core_clk) disable iff (!arst_n)
      (state_q == FLSQ_IDLE && start && two_write(reg_wdata[2:0]))
      |=> (flash_dq_out == CMD_LOCK_SETUP && !flash_we_n))
      else $error("setup byte not driven first");

   // Confirm byte matches the operation.
   confirm_byte_a : assert property (
      @(posedge core_clk) disable iff (!arst_n)
      $rose(state_q == FLSQ_WR2) |-> flash_dq_out == confirm_code(op_q))
      else $error("wrong confirm byte");

   // Reserved bit never appears in the captured status.
   reserved_zero_a : assert property (
      @(posedge core_clk) disable iff (!arst_n)
      status_q[0] == 1'b0)
      else $error("reserved bit not masked");

   // Status is taken only once the device reports ready.
   ready_capture_a : assert property (
      @(posedge core_clk) disable iff (!arst_n)
      $changed(status_q) && status_q != 8'h00 |-> $past(flash_dq_in[SR_READY]))
      else $error("status captured while busy");

   // Data bus is never driven while the output enable strobe is active.
   no_contention_a : assert property (
      @(posedge core_clk) disable iff (!arst_n)
      !flash_oe_n |-> !flash_dq_oe)
      else $error("bus contention");

   // Busy falls on the same edge that raises done.
   done_not_busy_a : assert property (
      @(posedge core_clk) disable iff (!arst_n)
      poll_done |=> done_q && !busy_q)
      else $error("busy still set after completion");

   // A status read with bit 7 low goes back to polling.
   busy_repoll_a : assert property (
      @(posedge core_clk) disable iff (!arst_n)
      (state_q == FLSQ_RD && cnt_q == 4'h0 && !flash_dq_in[SR_READY])
      |=> state_q == FLSQ_POLL)
      else $error("busy status not polled again");

   // Each write strobe lasts exactly three cycles.
   write_width_a : assert property (
      @(posedge core_clk) disable iff (!arst_n)
      $fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n)
      else $error("write strobe width wrong");

   // The address stays put while a write strobe is low.
   addr_hold_a : assert property (
      @(posedge core_clk) disable iff (!arst_n)
      !flash_we_n && $past(!flash_we_n) |-> $stable(flash_addr))
      else $error("address moved during write");
endmodule : flsq_host

// ### verification/flsq_flash_model.sv
// Behavioural flash device that answers lock-bit commands and status reads.
`timescale 1ns/1ps
module flsq_flash_model
   import flsq_pkg::*;
#(parameter int BUSY_CYC = 20)
(
   // Clock and power.
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   // Flash pins.
   input  wire logic [7:0] flash_dq_out,
   input  wire logic       flash_dq_oe,
   input  wire logic       flash_ce_n,
   input  wire logic       flash_we_n,
   input  wire logic       flash_oe_n,
   output logic      [7:0] flash_dq_in,
   output logic            ready_busy_output,
   // Bench side.
   input  wire logic       rp_hh,
   input  wire logic       vpp_ok,
   output logic      [7:0] last_cmd
);
   logic [7:0] sr_q;            // Sticky flags.
   logic [7:0] busy_q;          // Cycles left in the running operation.
   logic [7:0] last_q;          // Last value seen on the data lines.
   logic       setup_q;         // Setup byte seen.
   logic       pend_q;          // A bus write is under way.
   logic       master_q = 1'b0; // Master lock, kept over resets.
   // Status while read-enabled; the inverse of the last value otherwise.
   assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ?
      {busy_q == 8'h00, 1'b0, sr_q[5:3], 1'b0, sr_q[1], 1'b0} : ~last_q;
   assign ready_busy_output = busy_q == 8'h00;
   always_ff @(posedge core_clk) last_q <= flash_dq_in;
   // A command acts on the cycle after the write strobe returns high.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sr_q <= 8'h00;
         busy_q <= 8'h00;
         setup_q <= 1'b0;
         pend_q <= 1'b0;
         last_cmd <= 8'h00;
      end else begin
         if (busy_q != 8'h00) begin
            busy_q <= busy_q - 8'h01;
         end
         if (!flash_ce_n && !flash_we_n && flash_dq_oe) begin
            last_cmd <= flash_dq_out;
            pend_q <= 1'b1;
         end else if (pend_q && setup_q) begin
            pend_q <= 1'b0;
            setup_q <= 1'b0;
            busy_q <= 8'(BUSY_CYC);
            if (!vpp_ok) begin
               sr_q[3] <= 1'b1;
               sr_q[last_cmd == CMD_CLEAR_LOCKS ? 5 : 4] <= 1'b1;
            end else if (last_cmd == CMD_MASTER_LOCK) begin
               sr_q[1] <= sr_q[1] | !rp_hh;
               sr_q[4] <= sr_q[4] | !rp_hh;
               master_q <= master_q | rp_hh;
            end else if (last_cmd == CMD_BLOCK_LOCK || last_cmd == CMD_CLEAR_LOCKS) begin
               if (master_q && !rp_hh) begin
                  sr_q[1] <= 1'b1;
                  sr_q[last_cmd == CMD_BLOCK_LOCK ? 4 : 5] <= 1'b1;
               end
            end else begin
               sr_q[5:4] <= 2'b11;
            end
         end else if (pend_q) begin
            pend_q <= 1'b0;
            setup_q <= last_cmd == CMD_LOCK_SETUP;
            if (last_cmd == CMD_CLEAR_STATUS) begin
               sr_q <= 8'h00;
            end
         end
      end
   end
endmodule : flsq_flash_model

// ### verification/flash_status_and_lock_bit_sequencer_tb.sv
// Self-checking bench for the lock-bit host controller against the flash model.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module flash_status_and_lock_bit_sequencer_tb;
   import flsq_pkg::*;
   // One case: operation, pin level, supply, status and confirm byte expected.
   typedef struct packed {
      logic [2:0] op;
      logic       rp;
      logic       vpp;
      logic [7:0] st;
      logic [7:0] cmd;
   } flsq_row_t;
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        rp_hh = 1'b0;
   logic        vpp_ok = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata, d;
   logic [19:0] flash_addr;
   logic [7:0]  dq_out, dq_in, last_cmd;
   logic        oe, ce_n, we_n, oe_n, rdy;
   int          mismatches = 0;
   int          n_checks = 0;
   flsq_row_t   rows [9] = '{
      '{3'h1, 1'b0, 1'b1, 8'h80, 8'h01}, '{3'h3, 1'b0, 1'b0, 8'ha8, 8'hd0},
      '{3'h2, 1'b0, 1'b1, 8'h92, 8'hf1}, '{3'h2, 1'b1, 1'b1, 8'h80, 8'hf1},
      '{3'h1, 1'b0, 1'b1, 8'h92, 8'h01}, '{3'h3, 1'b0, 1'b1, 8'ha2, 8'hd0},
      '{3'h3, 1'b1, 1'b1, 8'h80, 8'hd0}, '{3'h1, 1'b1, 1'b0, 8'h98, 8'h01},
      '{3'h1, 1'b0, 1'b1, 8'h92, 8'h01}};
   always #25 core_clk = ~core_clk;
   flsq_host i_dut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .flash_addr(flash_addr), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
      .flash_dq_oe(oe), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
      .ready_busy_output(rdy));
   flsq_flash_model #(.BUSY_CYC(20)) i_flash (.core_clk(core_clk), .arst_n(arst_n),
      .flash_dq_out(dq_out), .flash_dq_oe(oe), .flash_ce_n(ce_n), .flash_we_n(we_n),
      .flash_oe_n(oe_n), .flash_dq_in(dq_in), .ready_busy_output(rdy), .rp_hh(rp_hh),
      .vpp_ok(vpp_ok), .last_cmd(last_cmd));
   // One-cycle register write.
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // One-cycle register read; the data is taken in the cycle after into d.
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask : rd
   // Starts an operation and waits until it has finished.
   task automatic run(input logic [2:0] op);
      int i;
      wr(A_ADDR, 32'h000a5);
      wr(A_CTRL, {29'h0, op});
      i = 0;
      d = 32'h0;
      if (op >= OP_CLEAR_STATUS) begin
         repeat (20) @(posedge core_clk);
         rd(A_RESULT);
      end else begin
         while (d[1] !== 1'b1 && i < 300) begin
            rd(A_RESULT);
            i++;
         end
      end
   endtask : run
   // Runs one case and checks the result flags, the wire command and the status.
   task automatic do_row(input flsq_row_t r);
      @(posedge core_clk);
      rp_hh <= r.rp;
      vpp_ok <= r.vpp;
      run(r.op);
      `CHK(d[2:0], {|(r.st & 8'h3a), 2'b10})
      `CHK(last_cmd, r.cmd)
      `CHK(flash_addr, 20'h000a5)
      rd(A_STATUS);
      `CHK(d[7:0], r.st)
   endtask : do_row
   // Prints the counts and the verdict, then stops.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   // Watchdog well beyond the expected run length.
   initial begin
      #2000000;
      mismatches++;
      tally_and_finish();
   end
   // Main sequence: table cases, then sticky errors, refusals and a mid-run reset.
   initial begin
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      `CHK({we_n, ce_n, oe_n, oe}, 4'he)
      `CHK(reg_rdata, 32'h0)
      foreach (rows[k]) begin
         run(OP_CLEAR_STATUS);
         do_row(rows[k]);
      end
      run(OP_CLEAR_STATUS);
      do_row('{3'h2, 1'b0, 1'b1, 8'h92, 8'hf1});
      do_row('{3'h3, 1'b1, 1'b0, 8'hba, 8'hd0});
      run(OP_CLEAR_STATUS);
      `CHK(last_cmd, CMD_CLEAR_STATUS)
      rd(A_STATUS);
      `CHK(d[7:0] & 8'h3a, 8'h00)
      run(OP_READ_ARRAY);
      `CHK(last_cmd, CMD_READ_ARRAY)
      wr(A_CTRL, 32'h0);
      rd(A_RESULT);
      `CHK(d[0], 1'b0)
      `CHK(last_cmd, CMD_READ_ARRAY)
      rd(4'hf);
      `CHK(d, 32'h0)
      rd(A_ADDR);
      `CHK(d, 32'h000a5)
      rd(A_CTRL);
      `CHK(d, {29'h0, OP_READ_ARRAY})
      wr(A_CTRL, {29'h0, OP_BLOCK_LOCK});
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b0;
      @(negedge core_clk);
      `CHK({we_n, ce_n, oe_n, oe}, 4'he)
      @(posedge core_clk);
      arst_n <= 1'b1;
      do_row('{3'h1, 1'b1, 1'b1, 8'h80, 8'h01});
      tally_and_finish();
   end
endmodule : flash_status_and_lock_bit_sequencer_tb
